// *** inc/sar_pkg.sv ***
// Package for the converter sequencer: register map, field layout, timing counts.
// Assumes a 32-bit APB slave with word-aligned registers.
package sar_pkg;

  // ********************
  // Register map
  // ********************
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_CHAN = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0C;
  localparam logic [7:0] OFF_COMP = 8'h10;
  localparam logic [7:0] OFF_DIDR = 8'h14;

  // ********************
  // Field positions
  // ********************
  localparam int CA_ENABLE = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_DONE = 4;
  localparam int CC_OUT = 5;
  localparam int CC_FLAG = 4;
  localparam int CC_IRQ_EN = 3;

  // ********************
  // Reset values, timing, trigger and comparator mode codes
  // ********************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] CYC_NORMAL = 5'h0D;
  localparam logic [4:0] CYC_FIRST = 5'h19;
  localparam logic [4:0] SH_NORMAL = 5'h03;
  localparam logic [4:0] SH_FIRST = 5'h10;
  localparam logic [4:0] SH_AUTO = 5'h02;
  localparam logic [2:0] TRIG_DONE = 3'h0;
  localparam logic [1:0] CMP_TOGGLE = 2'h0;
  localparam logic [1:0] CMP_FALL = 2'h2;
  localparam logic [1:0] CMP_RISE = 2'h3;

  typedef enum {ST_IDLE, ST_CONV} conv_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic sel;
    logic enable;
    logic [31:0] wdata;
  } apb_req_t;

endpackage

// *** core/sar_prescaler.sv ***
// Converter clock prescaler: produces one-cycle ticks of the converter clock.
// Assumes the enable and restart inputs come from the same clock domain.
module sar_prescaler
  import sar_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Control
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [2:0] divider_select_i,
  // Tick
  output logic tick_o
);

  typedef struct packed {
    logic [6:0] count;
  } pre_state_t;

  pre_state_t state;
  pre_state_t next_state;
  logic [6:0] limit;

  // ********************
  // Divide by 2 to 128
  // ********************
  always_comb begin
    limit = 7'h01;
    if (divider_select_i > 3'h1) begin
      limit = 7'((8'h01 << divider_select_i) - 8'h01);
    end
    next_state = state;
    if (!run_i || restart_i) begin
      next_state.count = 7'h00;
    end else if (state.count == limit) begin
      next_state.count = 7'h00;
    end else begin
      next_state.count = state.count + 7'h01;
    end
  end

  assign tick_o = run_i && !restart_i && (state.count == limit);

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// *** core/sar_converter_sequencer.sv ***
// Converter sequencer: APB registers, conversion timing, channel lock, comparator edges.
// Assumes an external SAR datapath answering with an 8-bit code at hold time.
module sar_converter_sequencer
  import sar_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Trigger sources, same clock domain
  input wire logic [7:0] trigger_sources_i,
  // Analog front end
  input wire logic [7:0] sar_code_i,
  input wire logic comparator_raw_i,
  input wire logic [1:0] port_pins_i,
  output logic [1:0] mux_select_o,
  output logic mux_enable_o,
  output logic sample_hold_o,
  output logic [1:0] input_buffer_off_o,
  output logic [1:0] port_read_o,
  output logic comparator_flag_o
);

  typedef struct packed {
    conv_state_t phase;
    logic enable;
    logic start;
    logic auto_en;
    logic done_flag;
    logic [2:0] divider;
    logic [2:0] trig_select;
    logic [1:0] chan_buf;
    logic [1:0] chan_eff;
    logic [7:0] result;
    logic [7:0] held_code;
    logic [4:0] cycle;
    logic [4:0] length;
    logic [4:0] hold_at;
    logic first;
    logic pending;
    logic trig_prev;
    logic [1:0] cmp_sync;
    logic cmp_prev;
    logic cmp_flag;
    logic cmp_irq_en;
    logic [1:0] cmp_mode;
    logic [1:0] didr;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic sample;
    logic [31:0] rdata;
  } seq_state_t;

  seq_state_t state;
  seq_state_t next_state;
  logic tick;
  logic restart;
  logic trig_level;
  logic trig_edge;
  logic wr;
  logic rd;
  logic cmp_event;
  logic cmp_now;
  logic done_now;
  logic [1:0] pin_masked;

  // ********************
  // Prescaler
  // ********************
  sar_prescaler prescaler (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .run_i(state.enable),
    .restart_i(restart),
    .divider_select_i(state.divider),
    .tick_o(tick)
  );

  // ********************
  // Bus and event decode
  // ********************
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && !penable_i && !pwrite_i;
  // Done flag as source is handled by completion, not by edge, so it never stalls
  assign trig_level = (state.trig_select == TRIG_DONE) ? 1'b0
                      : trigger_sources_i[state.trig_select];
  assign trig_edge = state.enable && state.auto_en && trig_level && !state.trig_prev;
  assign restart = trig_edge && (state.phase == ST_IDLE) && !state.pending;
  assign cmp_now = state.cmp_sync[1];
  always_comb begin
    case (state.cmp_mode)
      CMP_TOGGLE: cmp_event = cmp_now != state.cmp_prev;
      CMP_FALL: cmp_event = !cmp_now && state.cmp_prev;
      CMP_RISE: cmp_event = cmp_now && !state.cmp_prev;
      default: cmp_event = 1'b0;
    endcase
  end
  assign done_now = (state.phase == ST_CONV) && tick && (state.cycle == state.length);

  // ********************
  // Per-pin input disable
  // ********************
  // Masking before the register keeps a disabled pin at zero with no glitch
  for (genvar b = 0; b < 2; b++) begin : g_pin
    assign pin_masked[b] = state.pin_meta[b] && !state.didr[b];
  end

  // ********************
  // Sequencing
  // ********************
  always_comb begin
    next_state = state;
    next_state.sample = 1'b0;
    next_state.trig_prev = trig_level;
    next_state.cmp_sync = {state.cmp_sync[0], comparator_raw_i};
    next_state.cmp_prev = cmp_now;
    next_state.pin_meta = port_pins_i;
    next_state.pin_sync = pin_masked;
    if (cmp_event) begin
      next_state.cmp_flag = 1'b1;
    end else if (wr && paddr_i == OFF_COMP && pwdata_i[CC_FLAG]) begin
      next_state.cmp_flag = 1'b0;
    end
    // Locked during a conversion until its last cycle, so a late write cannot disturb the held sample
    if (state.enable && (state.phase == ST_IDLE || state.cycle == state.length)) begin
      next_state.chan_eff = state.chan_buf;
    end
    if (restart) begin
      next_state.pending = 1'b1;
      next_state.start = 1'b1;
    end
    case (state.phase)
      ST_IDLE: begin
        if (tick && (state.start || state.pending)) begin
          next_state.phase = ST_CONV;
          next_state.cycle = 5'h01;
          next_state.length = state.first ? CYC_FIRST : CYC_NORMAL;
          next_state.hold_at = state.first ? SH_FIRST : (state.pending ? SH_AUTO : SH_NORMAL);
          next_state.pending = 1'b0;
          next_state.first = 1'b0;
        end
      end
      ST_CONV: begin
        if (tick) begin
          next_state.cycle = state.cycle + 5'h01;
          if (state.cycle == state.hold_at) begin
            next_state.sample = 1'b1;
            next_state.held_code = sar_code_i;
          end
          if (done_now) begin
            next_state.result = state.held_code;
            next_state.done_flag = 1'b1;
            if (state.auto_en && state.trig_select == TRIG_DONE) begin
              next_state.cycle = 5'h01;
              next_state.length = CYC_NORMAL;
              next_state.hold_at = SH_NORMAL;
            end else begin
              next_state.phase = ST_IDLE;
              next_state.start = 1'b0;
            end
          end
        end
      end
      default: next_state.phase = ST_IDLE;
    endcase
    if (wr) begin
      case (paddr_i)
        OFF_CTRL_A: begin
          next_state.enable = pwdata_i[CA_ENABLE];
          next_state.auto_en = pwdata_i[CA_AUTO];
          next_state.divider = pwdata_i[2:0];
          if (pwdata_i[CA_START] && pwdata_i[CA_ENABLE]) begin
            next_state.start = 1'b1;
          end
          if (pwdata_i[CA_DONE] && !done_now) begin
            next_state.done_flag = 1'b0; // Set wins over clear
          end
          if (!state.enable && pwdata_i[CA_ENABLE]) begin
            next_state.first = 1'b1;
          end
          if (!pwdata_i[CA_ENABLE]) begin
            next_state.phase = ST_IDLE; // Disabling aborts any conversion
            next_state.start = 1'b0;
            next_state.pending = 1'b0;
          end
        end
        OFF_CTRL_B: next_state.trig_select = pwdata_i[2:0];
        OFF_CHAN: next_state.chan_buf = pwdata_i[1:0];
        OFF_COMP: begin
          next_state.cmp_irq_en = pwdata_i[CC_IRQ_EN];
          next_state.cmp_mode = pwdata_i[1:0];
        end
        OFF_DIDR: next_state.didr = pwdata_i[1:0];
        default: next_state.rdata = state.rdata;
      endcase
    end
    if (rd) begin
      case (paddr_i)
        OFF_CTRL_A: next_state.rdata = {24'h000000, state.enable, state.start, state.auto_en,
                                        state.done_flag, 1'b0, state.divider};
        OFF_CTRL_B: next_state.rdata = {29'h00000000, state.trig_select};
        OFF_CHAN: next_state.rdata = {30'h00000000, state.chan_buf};
        OFF_RESULT: next_state.rdata = {24'h000000, state.result};
        OFF_COMP: next_state.rdata = {26'h0000000, cmp_now, state.cmp_flag, state.cmp_irq_en,
                                      1'b0, state.cmp_mode};
        OFF_DIDR: next_state.rdata = {30'h00000000, state.didr};
        default: next_state.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign prdata_o = state.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign mux_select_o = state.chan_eff;
  assign mux_enable_o = state.enable;
  assign sample_hold_o = state.sample;
  assign input_buffer_off_o = state.didr;
  assign port_read_o = state.pin_sync;
  assign comparator_flag_o = state.cmp_flag;

endmodule

// *** bench/sar_seq_monitor.sv ***
// Port checker for the converter sequencer.
// Assumes a bind onto the sequencer, one clock domain.
module sar_seq_monitor (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Watched signals
  input wire logic comparator_raw_i,
  input wire logic [1:0] mux_select_o,
  input wire logic mux_enable_o,
  input wire logic sample_hold_o,
  input wire logic [1:0] input_buffer_off_o,
  input wire logic [1:0] port_read_o,
  input wire logic comparator_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ****************
  // Properties
  // ****************
  a_mux_idle: assert property (!mux_enable_o && $past(!mux_enable_o) |-> $stable(mux_select_o))
    else $error("channel moved while disabled");
  a_hold_single: assert property (sample_hold_o |=> !sample_hold_o)
    else $error("hold pulse longer than one cycle");
  a_hold_gap: assert property (sample_hold_o |=> (!sample_hold_o)[*8])
    else $error("holds too close together");
  a_hold_enabled: assert property (sample_hold_o |-> mux_enable_o)
    else $error("hold while converter off");
  a_mux_locked: assert property (sample_hold_o |-> $stable(mux_select_o) ##1 $stable(mux_select_o))
    else $error("channel moved around hold");
  a_off_zero0: assert property (input_buffer_off_o[0] && $past(input_buffer_off_o[0])
    && $past(input_buffer_off_o[0], 2) |-> !port_read_o[0])
    else $error("disabled input 0 reads one");
  a_off_zero1: assert property (input_buffer_off_o[1] && $past(input_buffer_off_o[1])
    && $past(input_buffer_off_o[1], 2) |-> !port_read_o[1])
    else $error("disabled input 1 reads one");
  // Sync and edge logic settle well inside six quiet cycles
  a_cmp_quiet: assert property (($stable(comparator_raw_i))[*6] |=> !$rose(comparator_flag_o))
    else $error("comparator flag without an edge");
endmodule
bind sar_converter_sequencer sar_seq_monitor mon (.clock_i(clock_i), .nrst_i(nrst_i),
  .comparator_raw_i(comparator_raw_i), .mux_select_o(mux_select_o),
  .mux_enable_o(mux_enable_o), .sample_hold_o(sample_hold_o),
  .input_buffer_off_o(input_buffer_off_o), .port_read_o(port_read_o),
  .comparator_flag_o(comparator_flag_o));

// *** bench/sar_front_model.sv ***
// Analog front end stand-in: one fixed code per channel.
// Assumes the code is captured at the hold pulse, after the channel locks.
module sar_front_model (
  // Multiplexer side
  input wire logic clock_i,
  input wire logic [1:0] mux_select_i,
  input wire logic mux_enable_i,
  // Code
  output logic [7:0] sar_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sar_code_o = 8'h00;
  // Ground, two mid codes, supply; off means a moving pattern, not the last code
  always @(posedge clock_i) begin
    if (!mux_enable_i) sar_code_o <= ~sar_code_o;
    else if (mux_select_i == 2'h0) sar_code_o <= 8'h00;
    else if (mux_select_i == 2'h1) sar_code_o <= 8'h5A;
    else if (mux_select_i == 2'h2) sar_code_o <= 8'hA5;
    else sar_code_o <= 8'hFF;
  end
endmodule

// *** bench/sar_converter_sequencer_bench.sv ***
// Self-checking bench: APB master, front end model, port checks.
// Assumes pready answers within the timeout; divider select 0 gives /2.
module sar_converter_sequencer_bench
  import sar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, nrst_i = 0, psel = 0, penable = 0, pwrite = 0, craw = 0;
  logic [7:0] paddr = 8'h00, trig = 8'h00, code;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [1:0] pins = 2'h0, mux_sel, buf_off, port_rd;
  logic pready, pslverr, mux_en, hold, cflag, serr;
  int failures = 0, cmp_count = 0, cyc = 0, holds = 0, hcyc = 0, seed = 32'h2490e0d7;
  int i, n, len, m, e, h0, t0;
  sar_converter_sequencer dut (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trigger_sources_i(trig),
    .sar_code_i(code), .comparator_raw_i(craw), .port_pins_i(pins), .mux_select_o(mux_sel),
    .mux_enable_o(mux_en), .sample_hold_o(hold), .input_buffer_off_o(buf_off),
    .port_read_o(port_rd), .comparator_flag_o(cflag));
  sar_front_model front (.clock_i(clock_i), .mux_select_i(mux_sel), .mux_enable_i(mux_en),
    .sar_code_o(code));
  // ****************
  // Helpers
  // ****************
  initial begin
    clock_i = 0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    holds <= holds + 32'(hold === 1'b1);
    if (hold === 1'b1) hcyc <= cyc;
    if (cyc > 5000) begin
      failures++;
      wrap_up();
    end
  end
  function automatic logic [7:0] exp_code(input int ch);
    return ch == 0 ? 8'h00 : ch == 1 ? 8'h5A : ch == 2 ? 8'hA5 : 8'hFF;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One idle cycle after release keeps psel from two assignments in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i) penable <= 1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock_i);
  endtask
  task wrap_up;
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (2) @(posedge clock_i);
    // Converter logic is clocked from the start: no power gate here
    nrst_i <= 1;
    @(posedge clock_i);
    for (i = 0; i < 7; i++) begin
      apb(0, 8'(i < 6 ? i * 4 : 32), 0);
      chk(rd, 0);
      chk(serr, 0);
    end
    apb(1, OFF_CHAN, 2);
    chk(mux_sel, 0);
    chk(mux_en, 0);
    $display("test done: reset values");
    for (i = 0; i < 4; i++) begin
      apb(1, OFF_CHAN, i);
      t0 = cyc;
      // Fastest divider keeps runs short; silicon needs a far slower converter clock
      apb(1, OFF_CTRL_A, 32'hD0);
      apb(1, OFF_CHAN, (i + 1) % 4);
      apb(0, OFF_CTRL_A, 0);
      chk(rd[CA_START], 1);
      do apb(0, OFF_CTRL_A, 0); while (rd[CA_START] === 1'b1);
      n = cyc - t0;
      len = i == 0 ? 50 : 26;
      chk(32'(n >= len - 2 && n <= len + 12), 1);
      chk(rd[CA_DONE], 1);
      chk(mux_sel, (i + 1) % 4);
      apb(0, OFF_RESULT, 0);
      chk(rd, exp_code(i));
    end
    $display("test done: single conversions");
    repeat (16) begin
      d = $random(seed);
      pins <= d[1:0];
      apb(1, OFF_DIDR, d[3:2]);
      repeat (4) @(posedge clock_i);
      chk(port_rd, d[1:0] & ~d[3:2]);
      chk(buf_off, d[3:2]);
    end
    $display("test done: input disable");
    for (m = 0; m < 4; m++) for (e = 0; e < 2; e++) begin
      craw <= 1'(!e);
      repeat (6) @(posedge clock_i);
      apb(1, OFF_COMP, 32'h10 | m);
      craw <= 1'(e);
      repeat (6) @(posedge clock_i);
      apb(0, OFF_COMP, 0);
      n = m == 0 || (m == 3 && e == 1) || (m == 2 && e == 0);
      chk(rd[CC_FLAG], n);
      chk(cflag, n);
      chk(rd[CC_OUT], e);
    end
    $display("test done: comparator modes");
    apb(1, OFF_CTRL_B, TRIG_DONE);
    apb(1, OFF_CTRL_A, 32'hF0);
    h0 = holds;
    repeat (200) @(posedge clock_i);
    apb(0, OFF_CTRL_A, 0);
    chk(rd[CA_START], 1);
    chk(32'(holds - h0 >= 6), 1);
    apb(1, OFF_CTRL_A, 0);
    $display("test done: free running");
    apb(1, OFF_CTRL_B, 1);
    apb(1, OFF_CTRL_A, 32'hB0);
    h0 = holds;
    trig <= 8'h02;
    repeat (10) @(posedge clock_i);
    trig <= 8'h00;
    repeat (4) @(posedge clock_i);
    trig <= 8'h02;
    repeat (120) @(posedge clock_i);
    chk(holds - h0, 1);
    trig <= 8'h00;
    repeat (2) @(posedge clock_i);
    h0 = holds;
    t0 = cyc;
    trig <= 8'h02;
    repeat (60) @(posedge clock_i);
    chk(holds - h0, 1);
    chk(32'(hcyc - t0 >= 3 && hcyc - t0 <= 10), 1);
    $display("test done: auto trigger");
    wrap_up();
  end
endmodule
